// ===== rtl/cup_consts.svh
// Offsets, field positions, reset values and timing counts of the current unbalance protection block
`ifndef CUP_CONSTS_SVH
`define CUP_CONSTS_SVH

`define CUP_OFF_CTRL 12'h000
`define CUP_OFF_THRESH 12'h004
`define CUP_OFF_DELAY 12'h008
`define CUP_OFF_STATUS 12'h00c
`define CUP_OFF_INT_STAT 12'h010
`define CUP_OFF_INT_MASK 12'h014
`define CUP_OFF_RATED 12'h018

`define CUP_CTRL_OPER_BIT 0
`define CUP_CTRL_START_ONLY_BIT 1
`define CUP_STAT_START_BIT 0
`define CUP_STAT_TRIP_BIT 1

`define CUP_THRESH_MIN 7'd10
`define CUP_THRESH_MAX 7'd90
`define CUP_THRESH_RESET 7'd50
`define CUP_DELAY_MIN_MS 16'd100
`define CUP_DELAY_MAX_MS 16'd60000
`define CUP_DELAY_RESET_MS 16'd1000
`define CUP_RATED_RESET 16'h1000

`define CUP_LOW_LIMIT_PCT 10
`define CUP_HIGH_LIMIT_PCT 150

`define CUP_CLK_PERIOD_NS 10
`define CUP_TICK_PERIOD_NS 1000000
`define CUP_TICK_CYCLES (`CUP_TICK_PERIOD_NS / `CUP_CLK_PERIOD_NS)

`endif

// ===== rtl/cup_pkg.sv
// Types shared by the current unbalance protection block
`default_nettype none
package cup_pkg;
  typedef logic [15:0] cup_mag_type;
  typedef logic [31:0] cup_word_type;
  typedef enum logic [1:0] {
    cup_idle,
    cup_timing,
    cup_tripped
  } cup_state_type;
endpackage
`default_nettype wire

// ===== rtl/cup_unbalance_protection_unit.sv
// Current unbalance protection decision block with APB register slave and interrupt
//
// Summary of operation
// [R01] Find largest and smallest phase magnitude
// [R02] Difference taken as percent of largest
// [R03] Start when percentage exceeds threshold, enabled
// [R04] Start only for largest within 10-150 percent
// [R05] Off or blocked holds start, trip low
// [R06] Trip after delay with start continuously present
// [R07] Start-only mode never asserts trip
// [R08] Threshold 10 to 90 percent, default 50
// [R09] Delay 100 to 60000 ms, default 1000
// [R10] Clear timer, drop trip when start ends
// [R11] Evaluate on strobe, timer on ms tick
`include "cup_consts.svh"
`default_nettype none
module cup_unbalance_protection_unit #(
  parameter int unsigned MAG_WIDTH = 16,
  parameter int unsigned TICK_CYCLES = `CUP_TICK_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire cup_pkg::cup_word_type pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Measurement stage
  input wire logic meas_valid,
  input wire cup_pkg::cup_mag_type phase1_current_magnitude,
  input wire cup_pkg::cup_mag_type phase2_current_magnitude,
  input wire cup_pkg::cup_mag_type phase3_current_magnitude,
  // User blocking
  input wire logic block_in,
  // Results
  output logic general_start,
  output logic general_trip,
  output logic irq
);
  import cup_pkg::*;

  initial begin
    if (MAG_WIDTH != 16) $error("MAG_WIDTH must be 16");
    if (TICK_CYCLES < 2) $error("TICK_CYCLES must be at least 2");
  end

  // Registers
  logic oper;
  logic start_only;
  logic [6:0] thresh;
  logic [15:0] delay_ms;
  logic [15:0] rated;
  logic [1:0] int_stat;
  logic [1:0] int_mask;

  // Evaluation state
  logic cond;
  logic [31:0] tick_cnt;
  logic tick;
  logic [15:0] ms_cnt;
  cup_state_type state;
  cup_state_type next_state;

  // APB decode
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire sel_ctrl = paddr == `CUP_OFF_CTRL;
  wire sel_thresh = paddr == `CUP_OFF_THRESH;
  wire sel_delay = paddr == `CUP_OFF_DELAY;
  wire sel_status = paddr == `CUP_OFF_STATUS;
  wire sel_istat = paddr == `CUP_OFF_INT_STAT;
  wire sel_imask = paddr == `CUP_OFF_INT_MASK;
  wire sel_rated = paddr == `CUP_OFF_RATED;
  wire mapped = sel_ctrl | sel_thresh | sel_delay | sel_status | sel_istat | sel_imask | sel_rated;
  // Out-of-range settings are refused with an error and keep the old value
  wire thresh_ok = pwdata[31:7] == 25'h0 && pwdata[6:0] >= `CUP_THRESH_MIN
                   && pwdata[6:0] <= `CUP_THRESH_MAX; // see [R08]
  wire delay_ok = pwdata[31:16] == 16'h0 && pwdata[15:0] >= `CUP_DELAY_MIN_MS
                  && pwdata[15:0] <= `CUP_DELAY_MAX_MS; // see [R09]
  wire bad = !mapped || (pwrite && sel_thresh && !thresh_ok) || (pwrite && sel_delay && !delay_ok)
             || (pwrite && sel_status);
  wire [31:0] rd_mux = sel_ctrl ? {30'h0, start_only, oper} :
                       sel_thresh ? {25'h0, thresh} :
                       sel_delay ? {16'h0, delay_ms} :
                       sel_status ? {30'h0, general_trip, general_start} :
                       sel_istat ? {30'h0, int_stat} :
                       sel_imask ? {30'h0, int_mask} :
                       sel_rated ? {16'h0, rated} : 32'h0;

  // Largest and smallest magnitude
  wire [15:0] p1 = phase1_current_magnitude;
  wire [15:0] p2 = phase2_current_magnitude;
  wire [15:0] p3 = phase3_current_magnitude;
  wire [15:0] max12 = (p1 > p2) ? p1 : p2;
  wire [15:0] min12 = (p1 < p2) ? p1 : p2;
  wire [15:0] imax = (max12 > p3) ? max12 : p3; // see [R01]
  wire [15:0] imin = (min12 < p3) ? min12 : p3; // see [R01]
  // Cross-multiplied so no divider is needed: diff*100 > thresh*imax
  wire [23:0] diff_pct = 24'((imax - imin) * 16'd100); // see [R02]
  wire [23:0] lim = 24'(imax * thresh); // see [R02]
  wire over = diff_pct > lim; // see [R03]
  wire [23:0] imax_pct = 24'(imax * 16'd100);
  wire [23:0] rated_lo = 24'(rated * 16'(`CUP_LOW_LIMIT_PCT));
  wire [23:0] rated_hi = 24'(rated * 16'(`CUP_HIGH_LIMIT_PCT));
  wire max_current_sufficient = imax_pct > rated_lo; // see [R04]
  wire max_current_not_fault = imax_pct < rated_hi; // see [R04]
  wire enabled = oper && !block_in; // see [R05]
  wire start_eval = over && max_current_sufficient && max_current_not_fault; // see [R03]
  wire active = enabled && cond; // see [R05]
  wire delay_done = ms_cnt >= delay_ms;
  wire next_start = active;
  wire next_trip = active && !start_only && (state == cup_tripped || (state == cup_timing && tick
                   && ms_cnt + 16'd1 >= delay_ms)); // see [R06] [R07]
  wire start_rise = next_start && !general_start;
  wire trip_rise = next_trip && !general_trip;

  // State sequence of the delay timer
  always_comb begin
    next_state = state;
    case (state)
      cup_idle: begin
        if (active) next_state = cup_timing;
      end
      cup_timing: begin
        if (!active) next_state = cup_idle; // see [R10]
        else if (next_trip) next_state = cup_tripped; // see [R06]
      end
      cup_tripped: begin
        if (!active || start_only) next_state = cup_idle; // see [R10] [R07]
      end
      default: next_state = cup_idle;
    endcase
  end

  // Register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oper <= 1'b0; // see [R05]
      start_only <= 1'b0; // see [R07]
      thresh <= `CUP_THRESH_RESET; // see [R08]
      delay_ms <= `CUP_DELAY_RESET_MS; // see [R09]
      rated <= `CUP_RATED_RESET;
      int_mask <= 2'h0;
    end else if (wr && !bad) begin
      if (sel_ctrl) begin
        oper <= pwdata[`CUP_CTRL_OPER_BIT];
        start_only <= pwdata[`CUP_CTRL_START_ONLY_BIT];
      end
      if (sel_thresh) thresh <= pwdata[6:0];
      if (sel_delay) delay_ms <= pwdata[15:0];
      if (sel_rated) rated <= pwdata[15:0];
      if (sel_imask) int_mask <= pwdata[1:0];
    end
  end

  // Sticky events: a new edge wins over a write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) int_stat <= 2'h0;
    else int_stat <= (int_stat & ~((wr && sel_istat) ? pwdata[1:0] : 2'h0)) | {trip_rise, start_rise};
  end

  // APB answer: zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && bad;
      prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h0;
    end
  end

  // Comparison result held between measurement updates
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cond <= 1'b0;
    else if (meas_valid) cond <= start_eval; // see [R11]
  end

  // Millisecond tick from the system clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 32'h0;
      tick <= 1'b0;
    end else begin
      tick <= tick_cnt == 32'(TICK_CYCLES - 2);
      tick_cnt <= (tick_cnt == 32'(TICK_CYCLES - 1)) ? 32'h0 : tick_cnt + 32'h1; // see [R11]
    end
  end

  // Delay counter and outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= cup_idle;
      ms_cnt <= 16'h0;
      general_start <= 1'b0;
      general_trip <= 1'b0;
      irq <= 1'b0;
    end else begin
      state <= next_state;
      if (!active) ms_cnt <= 16'h0; // see [R10]
      else if (tick && !delay_done) ms_cnt <= ms_cnt + 16'h1; // see [R11] [R09]
      general_start <= next_start;
      general_trip <= next_trip;
      irq <= |(int_stat & int_mask);
    end
  end
endmodule
`default_nettype wire

// ===== verif/cup_asserts.sv
// Port assertions of the unbalance protection unit
`default_nettype none
module cup_asserts (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Measurement and results
  input wire logic meas_valid,
  input wire logic block_in,
  input wire logic general_start,
  input wire logic general_trip
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready missing in access phase");
  property p_rdy1; pready |=> !pready; endproperty
  a_rdy1: assert property (p_rdy1) else $error("pready longer than one cycle");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  property p_prd0; !pready |-> prdata == 32'h0; endproperty
  a_prd0: assert property (p_prd0) else $error("prdata not zero outside access");
  property p_blk; block_in |=> !general_start && !general_trip; endproperty
  a_blk: assert property (p_blk) else $error("output active while blocked");
  property p_trip_start; general_trip |-> general_start || $past(general_start); endproperty
  a_trip_start: assert property (p_trip_start) else $error("trip without start");
  property p_trip_rise; $rose(general_trip) |-> $past(general_start) && $past(general_start, 8); endproperty
  a_trip_rise: assert property (p_trip_rise) else $error("trip rose without held start");
  // A start may only drop on a new evaluation, a block or a settings write
  property p_start_fall;
    $fell(general_start) |-> $past(meas_valid, 2) || $past(block_in) || $past(psel) || $past(psel, 2);
  endproperty
  a_start_fall: assert property (p_start_fall) else $error("start fell without cause");
  c_trip: cover property ($rose(general_trip));
  c_err: cover property (pslverr);
  c_blk: cover property (block_in && general_start);
endmodule
bind cup_unbalance_protection_unit cup_asserts i_cup_asserts (.*);
`default_nettype wire

// ===== verif/cup_meas_model.sv
// Measurement stage model: periodic strobe carrying three magnitudes
`default_nettype none
module cup_meas_model (
  // Clock and strobe spacing
  input wire logic pclk,
  input wire logic [7:0] per,
  // Requested magnitudes
  input wire cup_pkg::cup_mag_type s1,
  input wire cup_pkg::cup_mag_type s2,
  input wire cup_pkg::cup_mag_type s3,
  // To the unit
  output logic meas_valid,
  output cup_pkg::cup_mag_type phase1_current_magnitude,
  output cup_pkg::cup_mag_type phase2_current_magnitude,
  output cup_pkg::cup_mag_type phase3_current_magnitude
);
  import cup_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt = 8'h0;
  initial begin
    meas_valid = 0;
    phase1_current_magnitude = 0;
    phase2_current_magnitude = 0;
    phase3_current_magnitude = 0;
  end
  // Outside a strobe the lines carry the inverse, so a stale sample shows up
  always @(posedge pclk) begin
    cnt <= (cnt + 8'h1 >= per) ? 8'h0 : cnt + 8'h1;
    meas_valid <= cnt == 8'h0;
    phase1_current_magnitude <= cnt == 8'h0 ? s1 : ~s1;
    phase2_current_magnitude <= cnt == 8'h0 ? s2 : ~s2;
    phase3_current_magnitude <= cnt == 8'h0 ? s3 : ~s3;
  end
endmodule
`default_nettype wire

// ===== verif/tb.sv
// Self-checking bench of the unbalance protection unit
`default_nettype none
module tb;
  import cup_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, block_in = 0;
  logic [11:0] paddr = 0;
  cup_word_type pwdata = 0;
  logic [31:0] prdata;
  logic pready, pslverr, meas_valid, general_start, general_trip, irq;
  cup_mag_type phase1_current_magnitude, phase2_current_magnitude, phase3_current_magnitude;
  cup_mag_type s1 = 0, s2 = 0, s3 = 0;
  logic [7:0] per = 8'h05;
  int n_errors = 0, check_count = 0, thr = 90, rated = 100, n;
  always #5 pclk = ~pclk;
  cup_unbalance_protection_unit #(.TICK_CYCLES(10)) i_cup_unbalance_protection_unit (.*);
  cup_meas_model i_cup_meas_model (.*);
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (e !== g) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic e, logic [31:0] ed);
    int t;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    t = 0;
    do @(posedge pclk); while (pready !== 1 && ++t < 20);
    chk("pslverr", e, pslverr);
    if (!w) chk("prdata", ed, prdata);
    psel <= 0;
    penable <= 0;
  endtask
  function automatic logic model(int a, int b, int c);
    int mx, mn;
    mx = a > b ? a : b;
    mx = mx > c ? mx : c;
    mn = a < b ? a : b;
    mn = mn < c ? mn : c;
    return (mx - mn) * 100 > thr * mx && mx * 100 > rated * 10 && mx * 100 < rated * 150;
  endfunction
  task automatic meas(cup_mag_type a, cup_mag_type b, cup_mag_type c, logic en);
    s1 <= a;
    s2 <= b;
    s3 <= c;
    repeat (14) @(posedge pclk);
    chk("start", en && model(a, b, c), general_start);
  endtask
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    int ex[7];
    ex = '{0, 50, 1000, 0, 0, 0, 'h1000};
    void'($urandom(32'h698a647c));
    repeat (12) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk("start", 0, general_start);
    chk("trip", 0, general_trip);
    for (int i = 0; i < 7; i++) apb(0, 12'(4 * i), 0, 0, ex[i]);
    apb(0, 12'h01c, 0, 1, 0);
    apb(1, 12'h00c, 1, 1, 0);
    apb(1, 12'h004, 9, 1, 0);
    apb(1, 12'h004, 91, 1, 0);
    apb(1, 12'h008, 99, 1, 0);
    apb(1, 12'h008, 60001, 1, 0);
    apb(1, 12'h004, 90, 0, 0);
    apb(0, 12'h004, 0, 0, 90);
    apb(1, 12'h008, 100, 0, 0);
    apb(1, 12'h018, 100, 0, 0);
    meas(0, 100, 50, 0);
    apb(1, 12'h000, 1, 0, 0);
    meas(11, 0, 0, 1);
    meas(10, 0, 0, 1);
    meas(149, 0, 0, 1);
    meas(150, 0, 0, 1);
    for (int i = 0; i < 12; i++) begin
      thr = 10 + $urandom % 81;
      apb(1, 12'h004, thr, 0, 0);
      meas(16'($urandom % 200), 16'($urandom % 200), 16'($urandom % 200), 1);
    end
    meas(100, 100, 100, 1);
    meas(0, 100, 100, 1);
    n = 0;
    while (general_trip !== 1 && n < 1200) begin
      @(posedge pclk);
      n++;
    end
    chk("trip_time", 1, n > 970 && n < 1015);
    chk("irq", 0, irq);
    apb(1, 12'h014, 3, 0, 0);
    repeat (3) @(posedge pclk);
    chk("irq", 1, irq);
    apb(0, 12'h00c, 0, 0, 3);
    apb(0, 12'h010, 0, 0, 3);
    apb(1, 12'h010, 3, 0, 0);
    repeat (3) @(posedge pclk);
    chk("irq", 0, irq);
    block_in <= 1;
    repeat (3) @(posedge pclk);
    chk("start", 0, general_start);
    chk("trip", 0, general_trip);
    block_in <= 0;
    meas(0, 100, 100, 1);
    chk("trip", 0, general_trip);
    apb(1, 12'h000, 3, 0, 0);
    repeat (1100) @(posedge pclk);
    chk("trip", 0, general_trip);
    chk("start", 1, general_start);
    apb(1, 12'h000, 0, 0, 0);
    repeat (3) @(posedge pclk);
    chk("start", 0, general_start);
    tally_and_finish();
  end
  initial begin
    #100us;
    n_errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
